// ==== inc/xfl_pkg.sv ====
// Purpose: Shared constants for the FIFO latency report block
// Assumes: 32-bit register words, byte addresses on an 8-bit address port
// Notes: Delay counts are in 1/128ths of a measurement clock period
package xfl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 9;
  localparam int NUM_MEAS = 4;

  // Register byte addresses
  localparam logic [7:0] TX_DELAY_OFF = 8'h84;
  localparam logic [7:0] RX_DELAY_OFF = 8'h88;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h8C;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h90;
  localparam logic [7:0] CTRL_OFF = 8'h94;

  // Field layout shared by both delay registers
  localparam int PCS_VALID_BIT = 31;
  localparam int PCS_LSB = 16;
  localparam int CORE_VALID_BIT = 15;
  localparam int CORE_LSB = 0;

  // Control register: self-clearing command to drop all valid flags
  localparam int CTRL_CLR_VALID_BIT = 0;

  // Measurement index, also the bit position in status and mask
  localparam int MEAS_TX_PCS = 0;
  localparam int MEAS_TX_CORE = 1;
  localparam int MEAS_RX_PCS = 2;
  localparam int MEAS_RX_CORE = 3;

  // Count scale: latency = period * count / DELAY_DIVISOR
  localparam int DELAY_DIVISOR = 128;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [8:0] CNT_RESET = 9'h000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

endpackage : xfl_pkg

// ==== rtl/xfl_sync_capture.sv ====
// Purpose: Bring one measured delay count into the register clock domain
// Assumes: Source holds the count stable from one cycle before it flips
//          its toggle until its next toggle
// Notes: Count passes two flip-flops, toggle three; update is a pulse
`timescale 1ns/1ps
module xfl_sync_capture (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [8:0] src_cnt,
  input wire logic src_tgl,
  output logic [8:0] cnt_q,
  output logic upd_q
);

  logic [8:0] cnt_s1_q;
  logic [8:0] cnt_s1_d;
  logic [8:0] cnt_d;
  logic tgl_s1_q;
  logic tgl_s1_d;
  logic tgl_s2_q;
  logic tgl_s2_d;
  logic tgl_s3_q;
  logic tgl_s3_d;
  logic upd_d;

  always_comb begin
    cnt_s1_d = src_cnt;
    cnt_d = cnt_s1_q;
    tgl_s1_d = src_tgl;
    tgl_s2_d = tgl_s1_q;
    tgl_s3_d = tgl_s2_q;
    // Edge of the synchronised toggle marks a new measurement
    upd_d = tgl_s2_q ^ tgl_s3_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_s1_q <= xfl_pkg::CNT_RESET;
      cnt_q <= xfl_pkg::CNT_RESET;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      cnt_s1_q <= cnt_s1_d;
      cnt_q <= cnt_d;
      tgl_s1_q <= tgl_s1_d;
      tgl_s2_q <= tgl_s2_d;
      tgl_s3_q <= tgl_s3_d;
      upd_q <= upd_d;
    end
  end

endmodule : xfl_sync_capture

// ==== rtl/xfl_irq.sv ====
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Events are one-cycle pulses on ref_clk
// Notes: An event in the cycle of its clear keeps the bit set
`timescale 1ns/1ps
module xfl_irq (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] event_in,
  input wire logic stat_we,
  input wire logic [3:0] stat_w1c,
  input wire logic mask_we,
  input wire logic [3:0] mask_wdata,
  output logic [3:0] stat_q,
  output logic [3:0] mask_q,
  output logic irq_q
);

  logic [3:0] stat_d;
  logic [3:0] mask_d;
  logic irq_d;

  always_comb begin
    stat_d = stat_q;
    if (stat_we) begin
      stat_d = stat_d & ~stat_w1c;
    end
    // Set wins over clear
    stat_d = stat_d | event_in;
    mask_d = mask_we ? mask_wdata : mask_q;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_q <= xfl_pkg::FLAGS_RESET;
      mask_q <= xfl_pkg::FLAGS_RESET;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

endmodule : xfl_irq

// ==== rtl/xfl_top.sv ====
// Purpose: Read-only transceiver FIFO latency report registers
// Assumes: Measurements arrive from another clock as count plus toggle
// Notes: Reads return data in the cycle after the read strobe only
//
// How it works
// - Bit 31 of the transmit word is set once the transmit PCS delay is refreshed.
// - Bits 24:16 of the transmit word carry the 9-bit transmit PCS delay in 1/128 periods.
// - Bit 15 of the transmit word is set once the transmit core delay is refreshed.
// - Bits 8:0 of the transmit word carry the 9-bit transmit core delay in 1/128 periods.
// - The delay registers exist only when the block is built for the newer family.
// - The transmit word sits at 0x84, resets to zero and reads zero in bits 30:25 and 14:9.
// - The receive word sits at 0x88 and its bit 31 flags a refreshed receive PCS delay.
// - Bits 24:16 of the receive word carry the 9-bit receive PCS delay in 1/128 periods.
// - Bits 8:0 of the receive word carry the receive core delay, flagged by bit 15.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module xfl_top #(
  parameter bit HAS_XCVR_DELAY = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic irq,
  input wire logic [8:0] meas_tx_pcs_cnt,
  input wire logic meas_tx_pcs_tgl,
  input wire logic [8:0] meas_tx_core_cnt,
  input wire logic meas_tx_core_tgl,
  input wire logic [8:0] meas_rx_pcs_cnt,
  input wire logic meas_rx_pcs_tgl,
  input wire logic [8:0] meas_rx_core_cnt,
  input wire logic meas_rx_core_tgl
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [8:0] src_cnt [xfl_pkg::NUM_MEAS];
  logic src_tgl [xfl_pkg::NUM_MEAS];
  logic [8:0] sync_cnt [xfl_pkg::NUM_MEAS];
  logic [3:0] sync_upd;

  logic [8:0] cnt_q [xfl_pkg::NUM_MEAS];
  logic [8:0] cnt_d [xfl_pkg::NUM_MEAS];
  logic [3:0] valid_q;
  logic [3:0] valid_d;
  logic [3:0] upd_evt;

  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;

  logic stat_we;
  logic mask_we;
  logic clr_valid;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pack one delay word: PCS count and flag high, core count and flag low
  function automatic logic [31:0] pack_word(
    input logic pcs_valid,
    input logic [8:0] pcs_cnt,
    input logic core_valid,
    input logic [8:0] core_cnt
  );
    logic [31:0] w;
    w = xfl_pkg::WORD_RESET;
    w[xfl_pkg::PCS_VALID_BIT] = pcs_valid;
    w[xfl_pkg::PCS_LSB +: xfl_pkg::CNT_W] = pcs_cnt;
    w[xfl_pkg::CORE_VALID_BIT] = core_valid;
    w[xfl_pkg::CORE_LSB +: xfl_pkg::CNT_W] = core_cnt;
    return w;
  endfunction : pack_word

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(
    input logic we,
    input logic [7:0] a,
    input logic [7:0] off
  );
    return we && (a == off);
  endfunction : wr_hit

  // Four event flags in the low bits of an otherwise zero word
  function automatic logic [31:0] flags_word(
    input logic [3:0] flags
  );
    logic [31:0] w;
    w = xfl_pkg::WORD_RESET;
    w[xfl_pkg::NUM_MEAS-1:0] = flags;
    return w;
  endfunction : flags_word

  ////////////////////////////////////////////////////////////////////////////////
  // Measurement inputs into the register clock

  always_comb begin
    src_cnt[xfl_pkg::MEAS_TX_PCS] = meas_tx_pcs_cnt;
    src_cnt[xfl_pkg::MEAS_TX_CORE] = meas_tx_core_cnt;
    src_cnt[xfl_pkg::MEAS_RX_PCS] = meas_rx_pcs_cnt;
    src_cnt[xfl_pkg::MEAS_RX_CORE] = meas_rx_core_cnt;
    src_tgl[xfl_pkg::MEAS_TX_PCS] = meas_tx_pcs_tgl;
    src_tgl[xfl_pkg::MEAS_TX_CORE] = meas_tx_core_tgl;
    src_tgl[xfl_pkg::MEAS_RX_PCS] = meas_rx_pcs_tgl;
    src_tgl[xfl_pkg::MEAS_RX_CORE] = meas_rx_core_tgl;
  end

  for (genvar i = 0; i < xfl_pkg::NUM_MEAS; i++) begin : g_meas
    xfl_sync_capture u_cap (
      .ref_clk(ref_clk),
      .rst(rst),
      .src_cnt(src_cnt[i]),
      .src_tgl(src_tgl[i]),
      .cnt_q(sync_cnt[i]),
      .upd_q(sync_upd[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Delay counts and valid flags

  always_comb begin
    // Variants without the delay registers never see an update
    upd_evt = HAS_XCVR_DELAY ? sync_upd : xfl_pkg::FLAGS_RESET;
    valid_d = valid_q;
    if (clr_valid) begin
      valid_d = xfl_pkg::FLAGS_RESET;
    end
    // Count and flag load in the same cycle; a new update beats a clear
    valid_d = valid_d | upd_evt;
    for (int i = 0; i < xfl_pkg::NUM_MEAS; i++) begin
      cnt_d[i] = upd_evt[i] ? sync_cnt[i] : cnt_q[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      valid_q <= xfl_pkg::FLAGS_RESET;
      for (int i = 0; i < xfl_pkg::NUM_MEAS; i++) begin
        cnt_q[i] <= xfl_pkg::CNT_RESET;
      end
    end else begin
      valid_q <= valid_d;
      for (int i = 0; i < xfl_pkg::NUM_MEAS; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Update events, mask and interrupt

  always_comb begin
    stat_we = wr_hit(wr_en, addr, xfl_pkg::IRQ_STAT_OFF);
    mask_we = wr_hit(wr_en, addr, xfl_pkg::IRQ_MASK_OFF);
    // Only a one in the clear bit acts, other control bits stay free
    clr_valid = wr_hit(wr_en, addr, xfl_pkg::CTRL_OFF)
      && wr_data[xfl_pkg::CTRL_CLR_VALID_BIT];
  end

  xfl_irq u_irq (
    .ref_clk(ref_clk),
    .rst(rst),
    .event_in(upd_evt),
    .stat_we(stat_we),
    .stat_w1c(wr_data[xfl_pkg::NUM_MEAS-1:0]),
    .mask_we(mask_we),
    .mask_wdata(wr_data[xfl_pkg::NUM_MEAS-1:0]),
    .stat_q(stat_q),
    .mask_q(mask_q),
    .irq_q(irq_q)
  );

  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_comb begin
    // Data stand only in the cycle after the strobe; unmapped reads zero
    rd_data_d = xfl_pkg::WORD_RESET;
    if (rd_en) begin
      case (addr)
        xfl_pkg::TX_DELAY_OFF: begin
          if (HAS_XCVR_DELAY) begin
            rd_data_d = pack_word(valid_q[xfl_pkg::MEAS_TX_PCS],
                                  cnt_q[xfl_pkg::MEAS_TX_PCS],
                                  valid_q[xfl_pkg::MEAS_TX_CORE],
                                  cnt_q[xfl_pkg::MEAS_TX_CORE]);
          end
        end
        xfl_pkg::RX_DELAY_OFF: begin
          if (HAS_XCVR_DELAY) begin
            rd_data_d = pack_word(valid_q[xfl_pkg::MEAS_RX_PCS],
                                  cnt_q[xfl_pkg::MEAS_RX_PCS],
                                  valid_q[xfl_pkg::MEAS_RX_CORE],
                                  cnt_q[xfl_pkg::MEAS_RX_CORE]);
          end
        end
        xfl_pkg::IRQ_STAT_OFF: begin
          rd_data_d = flags_word(stat_q);
        end
        xfl_pkg::IRQ_MASK_OFF: begin
          rd_data_d = flags_word(mask_q);
        end
        default: begin
          rd_data_d = xfl_pkg::WORD_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= xfl_pkg::WORD_RESET;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

endmodule : xfl_top

// ==== bench/xfl_props.sv ====
// Purpose: Concurrent checks on the latency report register port
// Assumes: Toggles of one channel at least 10 cycles apart
// Notes: Bound into xfl_top
`timescale 1ns/1ps
module xfl_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic [8:0] meas_tx_pcs_cnt,
  input wire logic meas_tx_pcs_tgl,
  input wire logic [8:0] meas_tx_core_cnt,
  input wire logic meas_tx_core_tgl,
  input wire logic [8:0] meas_rx_pcs_cnt,
  input wire logic meas_rx_pcs_tgl,
  input wire logic [8:0] meas_rx_core_cnt,
  input wire logic meas_rx_core_tgl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (rd_en && addr < 8'h84 |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  AST_TX_RSVD: assert property (rd_en && addr == 8'h84 |=> {rd_data[30:25], rd_data[14:9]} == 12'h0)
    else $error("tx reserved bits set");
  AST_RX_RSVD: assert property (rd_en && addr == 8'h88 |=> {rd_data[30:25], rd_data[14:9]} == 12'h0)
    else $error("rx reserved bits set");
  // A set flag must come with the settled count, never a stale one
  AST_TX_PCS: assert property (rd_en && addr == 8'h84 && $past(meas_tx_pcs_tgl, 6) == meas_tx_pcs_tgl
    && $past(meas_tx_pcs_cnt, 6) == meas_tx_pcs_cnt |=> !rd_data[31] || rd_data[24:16] == $past(meas_tx_pcs_cnt))
    else $error("tx pcs count torn");
  AST_TX_CORE: assert property (rd_en && addr == 8'h84 && $past(meas_tx_core_tgl, 6) == meas_tx_core_tgl
    && $past(meas_tx_core_cnt, 6) == meas_tx_core_cnt |=> !rd_data[15] || rd_data[8:0] == $past(meas_tx_core_cnt))
    else $error("tx core count torn");
  AST_RX_PCS: assert property (rd_en && addr == 8'h88 && $past(meas_rx_pcs_tgl, 6) == meas_rx_pcs_tgl
    && $past(meas_rx_pcs_cnt, 6) == meas_rx_pcs_cnt |=> !rd_data[31] || rd_data[24:16] == $past(meas_rx_pcs_cnt))
    else $error("rx pcs count torn");
  AST_RX_CORE: assert property (rd_en && addr == 8'h88 && $past(meas_rx_core_tgl, 6) == meas_rx_core_tgl
    && $past(meas_rx_core_cnt, 6) == meas_rx_core_cnt |=> !rd_data[15] || rd_data[8:0] == $past(meas_rx_core_cnt))
    else $error("rx core count torn");
endmodule : xfl_props
bind xfl_top xfl_props u_props (.ref_clk(ref_clk), .rst(rst), .addr(addr), .rd_en(rd_en),
  .rd_data(rd_data), .meas_tx_pcs_cnt(meas_tx_pcs_cnt), .meas_tx_pcs_tgl(meas_tx_pcs_tgl),
  .meas_tx_core_cnt(meas_tx_core_cnt), .meas_tx_core_tgl(meas_tx_core_tgl),
  .meas_rx_pcs_cnt(meas_rx_pcs_cnt), .meas_rx_pcs_tgl(meas_rx_pcs_tgl),
  .meas_rx_core_cnt(meas_rx_core_cnt), .meas_rx_core_tgl(meas_rx_core_tgl));

// ==== bench/xfl_tb.sv ====
// Purpose: Register level tests of the latency report block
// Assumes: Channel index 0..3 is tx pcs, tx core, rx pcs, rx core
// Notes: Measurements are driven from the bench clock
`timescale 1ns/1ps
module xfl_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic irq;
  logic [31:0] rd_data_off;
  logic irq_off;
  logic [8:0] cnt [4] = '{default: 9'h000};
  logic [3:0] tgl = 4'h0;
  int n_errors = 0;
  int samples_checked = 0;
  always #25 ref_clk = ~ref_clk;
  xfl_top #(.HAS_XCVR_DELAY(1'b1)) dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .meas_tx_pcs_cnt(cnt[0]), .meas_tx_pcs_tgl(tgl[0]), .meas_tx_core_cnt(cnt[1]),
    .meas_tx_core_tgl(tgl[1]), .meas_rx_pcs_cnt(cnt[2]), .meas_rx_pcs_tgl(tgl[2]),
    .meas_rx_core_cnt(cnt[3]), .meas_rx_core_tgl(tgl[3]));
  // Variant built without the delay registers shares the bus and inputs
  xfl_top #(.HAS_XCVR_DELAY(1'b0)) dut_off (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data_off), .irq(irq_off),
    .meas_tx_pcs_cnt(cnt[0]), .meas_tx_pcs_tgl(tgl[0]), .meas_tx_core_cnt(cnt[1]),
    .meas_tx_core_tgl(tgl[1]), .meas_rx_pcs_cnt(cnt[2]), .meas_rx_pcs_tgl(tgl[2]),
    .meas_rx_core_cnt(cnt[3]), .meas_rx_core_tgl(tgl[3]));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rd_chk
  // Count settles one cycle ahead of its toggle
  task meas(input int i, input logic [8:0] v);
    @(posedge ref_clk);
    cnt[i] <= v;
    @(posedge ref_clk);
    tgl[i] <= ~tgl[i];
    repeat (10) @(posedge ref_clk);
  endtask : meas
  task results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    $display("watchdog expired");
    results();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(8'h84, 32'h0);
    rd_chk(8'h88, 32'h0);
    rd_chk(8'h00, 32'h0);
    wr(8'h84, 32'hFFFF_FFFF);
    rd_chk(8'h84, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    wr(8'h90, 32'h0000_000F);
    meas(0, 9'h1FF);
    meas(1, 9'h155);
    meas(2, 9'h0AA);
    meas(3, 9'h101);
    rd_chk(8'h84, 32'h81FF_8155);
    chk(rd_data_off, 32'h0);
    rd_chk(8'h88, 32'h80AA_8101);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, irq_off}, 32'h0);
    rd_chk(8'h8C, 32'h0000_000F);
    chk(rd_data_off, 32'h0);
    wr(8'h8C, 32'h0000_000F);
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test capture done");
    meas(0, 9'h000);
    rd_chk(8'h84, 32'h8000_8155);
    wr(8'h94, 32'h0000_0001);
    rd_chk(8'h84, 32'h0000_0155);
    rd_chk(8'h88, 32'h00AA_0101);
    wr(8'h90, 32'h0);
    meas(3, 9'h0FF);
    #1 chk({31'h0, irq}, 32'h0);
    rd_chk(8'h88, 32'h00AA_80FF);
    $display("test refresh done");
    results();
  end
endmodule : xfl_tb
